// File: dct_ctrl_end.sv
`timescale 1ns/10ps
module dct_ctrl_end (
  // Clock and reset.
  input  wire logic                                 sys_clk,
  input  wire logic                                 sys_rst,
  // Link to the memory.
  dct_link_if.ctrl                                  link,
  // Request side.
  input  wire logic                                 reqValid,
  output      logic                                 reqReady,
  input  wire dct_pkg::dct_op_t                     reqOp,
  input  wire logic [dct_pkg::BANK_W-1:0]           reqBank,
  input  wire logic [dct_pkg::ADDR_W-1:0]           reqAddr,
  input  wire logic [dct_pkg::BURST_WORDS*dct_pkg::DQ_W-1:0] reqWrData,
  // Read answer.
  output      logic                                 rspValid,
  output      logic [dct_pkg::BURST_WORDS*dct_pkg::DQ_W-1:0] rspData,
  // Status.
  output      logic                                 dllOffClkOk
);
  import dct_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACT  = 3'h1,
    ST_COL  = 3'h2,
    ST_PRE  = 3'h3,
    ST_MODE = 3'h4
  } dct_state_t;

  dct_state_t        state;
  dct_state_t        next_state;
  dct_cmd_t          next_cmd;
  dct_op_t           opReg;
  logic [BANK_W-1:0] bankReg;
  logic [ADDR_W-1:0] addrReg;
  logic [DQ_W-1:0]   wrHold [BURST_WORDS];
  logic [DQ_W-1:0]   wrBuf [BURST_WORDS];
  dct_cnt_t          actWait [NUM_BANKS];
  logic [NUM_BANKS-1:0] bankIdle;
  logic              actSetEn;
  dct_cnt_t          actVal;
  dct_cnt_t          rcdWait;
  dct_cnt_t          rasWait;
  dct_cnt_t          preWait;
  dct_cnt_t          colWait;
  dct_cnt_t          wtrWait;
  dct_cnt_t          mrdWait;
  dct_cnt_t          modWait;
  dct_cnt_t          rdCnt;
  dct_cnt_t          wrCnt;
  dct_cnt_t          next_wrCnt;
  logic [BEAT_W-1:0] rdBeat;
  logic [BEAT_W-1:0] wrBeat;
  logic              wrDrive;
  logic              wrData;
  logic              seqIdle;

  function automatic dct_cnt_t cnt_dec(input dct_cnt_t c);
    return (c == 6'h00) ? 6'h00 : c - 6'h01;
  endfunction : cnt_dec

  // The link clock is sys_clk; flag whether it is slow enough for DLL-off use.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dllOffClkOk <= 1'b0;
    end else begin
      dllOffClkOk <= (CK_PS >= DLL_OFF_CK_MIN_PS);
    end
  end

  assign reqReady = (state == ST_IDLE);
  assign seqIdle  = (rdCnt == 6'h00) && (wrCnt == 6'h00);

  always_ff @(posedge sys_clk) begin
    if (reqValid && reqReady) begin
      opReg   <= reqOp;
      bankReg <= reqBank;
      addrReg <= reqAddr;
      for (int i = 0; i < BURST_WORDS; i++) begin
        wrHold[i] <= reqWrData[i*DQ_W +: DQ_W];
      end
    end
  end

  // Closed-page sequencing: activate, column, then precharge or auto-precharge.
  always_comb begin
    next_state = state;
    next_cmd   = CMD_NOP;
    actSetEn   = 1'b0;
    actVal     = 6'h00;
    unique case (state)
      ST_IDLE: begin
        if (reqValid) begin
          next_state = (reqOp == OP_MRS) ? ST_MODE : ST_ACT;
        end
      end
      ST_ACT: begin
        if (actWait[bankReg] == 6'h00 && modWait == 6'h00) begin
          next_cmd   = CMD_ACT;
          actSetEn   = 1'b1;
          actVal     = RC_CYC - 6'h01;
          next_state = ST_COL;
        end
      end
      ST_COL: begin
        if (rcdWait == 6'h00 && colWait == 6'h00 && seqIdle &&
            (opReg != OP_RD || wtrWait == 6'h00)) begin
          if (opReg == OP_RD) begin
            next_cmd   = CMD_RD;
            next_state = ST_PRE;
          end else begin
            next_cmd   = CMD_WRA;
            actSetEn   = 1'b1;
            actVal     = CAS_WR_LAT + BURST_CYC + DAL_CYC - 6'h01;
            next_state = ST_IDLE;
          end
        end
      end
      ST_PRE: begin
        if (preWait == 6'h00 && rasWait == 6'h00) begin
          next_cmd   = CMD_PRE;
          actSetEn   = 1'b1;
          actVal     = RP_CYC - 6'h01;
          next_state = ST_IDLE;
        end
      end
      ST_MODE: begin
        if (&bankIdle && mrdWait == 6'h00) begin
          next_cmd   = CMD_MRS;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      link.cmd  <= CMD_NOP;
      link.bank <= '0;
      link.addr <= '0;
    end else begin
      state    <= next_state;
      link.cmd <= next_cmd;
      if (next_cmd != CMD_NOP) begin
        link.bank <= bankReg;
        link.addr <= addrReg;
      end
    end
  end

  // Per-bank wait before the next activate; the longest pending wait wins.
  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          actWait[b] <= 6'h00;
        end else if (actSetEn && bankReg == BANK_W'(b) && actVal > cnt_dec(actWait[b])) begin
          actWait[b] <= actVal;
        end else begin
          actWait[b] <= cnt_dec(actWait[b]);
        end
      end
      assign bankIdle[b] = (actWait[b] == 6'h00);
    end
  endgenerate

  // Spacing timers load on their command and count down to zero; the
  // write-to-read wait starts once the burst has been taken in.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rcdWait <= 6'h00;
      rasWait <= 6'h00;
      preWait <= 6'h00;
      colWait <= 6'h00;
      wtrWait <= 6'h00;
      mrdWait <= 6'h00;
      modWait <= 6'h00;
    end else begin
      rcdWait <= (next_cmd == CMD_ACT) ? RCD_CYC - 6'h01 : cnt_dec(rcdWait);
      rasWait <= (next_cmd == CMD_ACT) ? RAS_CYC - 6'h01 : cnt_dec(rasWait);
      preWait <= (next_cmd == CMD_RD) ? RTP_CYC - 6'h01 : cnt_dec(preWait);
      colWait <= (next_cmd inside {CMD_RD, CMD_WRA}) ? CCD_CYC - 6'h01 : cnt_dec(colWait);
      wtrWait <= (next_cmd == CMD_WRA) ? CAS_WR_LAT + BURST_CYC + WTR_CYC - 6'h01
                                       : cnt_dec(wtrWait);
      mrdWait <= (next_cmd == CMD_MRS) ? MRD_CYC - 6'h01 : cnt_dec(mrdWait);
      modWait <= (next_cmd == CMD_MRS) ? MOD_CYC - 6'h01 : cnt_dec(modWait);
    end
  end

  // Write burst: strobe from write latency minus the preamble, through the postamble.
  always_comb begin
    next_wrCnt = 6'h00;
    if (link.cmd == CMD_WRA) begin
      next_wrCnt = 6'h01;
    end else if (wrCnt != 6'h00 && wrCnt != WR_END) begin
      next_wrCnt = wrCnt + 6'h01;
    end
  end

  assign wrDrive = (next_wrCnt >= CAS_WR_LAT - PRE_AMB_CYC) &&
                   (next_wrCnt <= WR_END - 6'h01 + POST_AMB_CYC) && (next_wrCnt != 6'h00);
  assign wrData  = (next_wrCnt >= CAS_WR_LAT) && (next_wrCnt < WR_END);
  assign wrBeat  = BEAT_W'(next_wrCnt - CAS_WR_LAT);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrCnt <= 6'h00;
    end else begin
      wrCnt <= next_wrCnt;
      if (link.cmd == CMD_WRA) begin
        wrBuf <= wrHold;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link.ctrlDqsOeN <= 1'b1;
      link.ctrlDqs    <= 1'b0;
      link.ctrlDqOeN  <= 1'b1;
      link.ctrlDq     <= '0;
    end else begin
      link.ctrlDqsOeN <= !wrDrive;
      link.ctrlDqs    <= wrData && !wrBeat[0];
      link.ctrlDqOeN  <= !wrData;
      if (wrData) begin
        link.ctrlDq <= wrBuf[wrBeat];
      end
    end
  end

  // Read capture: one word a cycle from read latency onward.
  assign rdBeat = BEAT_W'(rdCnt - CAS_LAT);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdCnt    <= 6'h00;
      rspData  <= '0;
      rspValid <= 1'b0;
    end else begin
      if (link.cmd == CMD_RD) begin
        rdCnt <= 6'h01;
      end else if (rdCnt != 6'h00) begin
        rdCnt <= (rdCnt == RD_END) ? 6'h00 : rdCnt + 6'h01;
      end
      rspValid <= (rdCnt == RD_END - 6'h01);
      if (rdCnt >= CAS_LAT && rdCnt < RD_END) begin
        rspData[int'(rdBeat)*DQ_W +: DQ_W] <= link.dq;
      end
    end
  end

endmodule : dct_ctrl_end

// File: dct_dram_end.sv
`timescale 1ns/10ps
module dct_dram_end (
  // Clock and reset.
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // Link from the controller.
  dct_link_if.dram                     link,
  // Status.
  output      logic [dct_pkg::NUM_BANKS-1:0] bankOpen,
  output      logic [dct_pkg::NUM_BANKS-1:0] bankBusy,
  output      logic [dct_pkg::MODE_WR_W-1:0] modeWr,
  output      logic                    cmdError
);
  import dct_pkg::*;

  logic [DQ_W-1:0]   mem [MEM_DEPTH];
  dct_cnt_t          dalWait [NUM_BANKS];
  dct_cnt_t          rdCnt;
  dct_cnt_t          next_rdCnt;
  dct_cnt_t          wrCnt;
  logic [BANK_W-1:0] rdBank;
  logic [ADDR_W-1:0] rdAddr;
  logic [BANK_W-1:0] wrBank;
  logic [ADDR_W-1:0] wrAddr;
  logic [BEAT_W-1:0] rdBeat;
  logic [BEAT_W-1:0] wrBeat;
  logic              rdDrive;
  logic              rdData;
  logic              wrData;
  logic              badCmd;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      modeWr <= WR_PROG;
    end else if (link.cmd == CMD_MRS) begin
      modeWr <= link.addr[MODE_WR_W-1:0];
    end
  end

  // Each bank is opened by an activate and closed by a precharge or an
  // auto-precharge write, which keeps it busy for write latency, burst, write recovery and precharge.
  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic hit;
      assign hit = (link.bank == BANK_W'(b));
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          bankOpen[b] <= 1'b0;
        end else if (hit && link.cmd == CMD_ACT && dalWait[b] == 6'h00) begin
          bankOpen[b] <= 1'b1;
        end else if (hit && (link.cmd == CMD_PRE || link.cmd == CMD_WRA)) begin
          bankOpen[b] <= 1'b0;
        end
      end
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          dalWait[b] <= 6'h00;
        end else if (hit && link.cmd == CMD_WRA) begin
          dalWait[b] <= CAS_WR_LAT + BURST_CYC + RP_CYC + dct_cnt_t'(modeWr) - 6'h01;
        end else if (dalWait[b] != 6'h00) begin
          dalWait[b] <= dalWait[b] - 6'h01;
        end
      end
      assign bankBusy[b] = (dalWait[b] != 6'h00);
    end
  endgenerate

  always_comb begin
    badCmd = 1'b0;
    unique case (link.cmd)
      CMD_ACT: badCmd = bankOpen[link.bank] || bankBusy[link.bank];
      CMD_RD,
      CMD_WRA: badCmd = !bankOpen[link.bank];
      CMD_NOP,
      CMD_MRS,
      CMD_PRE: badCmd = 1'b0;
      default: badCmd = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmdError <= 1'b0;
    end else begin
      cmdError <= badCmd;
    end
  end

  // Read sequence: count cycles since the read command.
  always_comb begin
    next_rdCnt = 6'h00;
    if (link.cmd == CMD_RD) begin
      next_rdCnt = 6'h01;
    end else if (rdCnt != 6'h00 && rdCnt != RD_END) begin
      next_rdCnt = rdCnt + 6'h01;
    end
  end

  assign rdDrive = (next_rdCnt >= CAS_LAT - PRE_AMB_CYC) &&
                   (next_rdCnt <= RD_END - 6'h01 + POST_AMB_CYC) && (next_rdCnt != 6'h00);
  assign rdData  = (next_rdCnt >= CAS_LAT) && (next_rdCnt < RD_END);
  assign rdBeat  = BEAT_W'(next_rdCnt - CAS_LAT);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdCnt  <= 6'h00;
      rdBank <= '0;
      rdAddr <= '0;
    end else begin
      rdCnt <= next_rdCnt;
      if (link.cmd == CMD_RD) begin
        rdBank <= link.bank;
        rdAddr <= link.addr;
      end
    end
  end

  // Strobe drive opens one cycle before read latency and closes after the postamble.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link.dramDqsOeN <= 1'b1;
      link.dramDqs    <= 1'b0;
      link.dramDqOeN  <= 1'b1;
      link.dramDq     <= '0;
    end else begin
      link.dramDqsOeN <= !rdDrive;
      link.dramDqs    <= rdData && !rdBeat[0];
      link.dramDqOeN  <= !rdData;
      if (rdData) begin
        link.dramDq <= mem[{rdBank, rdAddr[ADDR_W-1:BEAT_W], rdBeat}];
      end
    end
  end

  // Write sequence: capture the burst at write latency.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrCnt  <= 6'h00;
      wrBank <= '0;
      wrAddr <= '0;
    end else if (link.cmd == CMD_WRA) begin
      wrCnt  <= 6'h01;
      wrBank <= link.bank;
      wrAddr <= link.addr;
    end else if (wrCnt != 6'h00) begin
      wrCnt <= (wrCnt == WR_END) ? 6'h00 : wrCnt + 6'h01;
    end
  end

  assign wrData = (wrCnt >= CAS_WR_LAT) && (wrCnt < WR_END);
  assign wrBeat = BEAT_W'(wrCnt - CAS_WR_LAT);

  always_ff @(posedge sys_clk) begin
    if (wrData) begin
      mem[{wrBank, wrAddr[ADDR_W-1:BEAT_W], wrBeat}] <= link.dq;
    end
  end

endmodule : dct_dram_end

// File: dct_link_checker.sv
`timescale 1ns/10ps
module dct_link_checker (
  // Clock and reset.
  input wire logic                        sys_clk,
  input wire logic                        sys_rst,
  // Command lines.
  input wire dct_pkg::dct_cmd_t           cmd,
  input wire logic [dct_pkg::BANK_W-1:0]  bank,
  // Strobe lines of both ends.
  input wire logic                        ctrlDqs,
  input wire logic                        ctrlDqsOeN,
  input wire logic                        dramDqs,
  input wire logic                        dramDqsOeN
);
  import dct_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  localparam int DalWait = int'(WR_END) + int'(DAL_CYC) - 1;

  logic [5:0]        dalCnt;
  logic [BANK_W-1:0] dalBank;
  logic              isCol;
  logic              quiet;

  assign isCol = (cmd == CMD_RD) || (cmd == CMD_WRA);
  assign quiet = (cmd == CMD_NOP) || (cmd == CMD_MRS);

  // Counts down the cycles in which the last written bank may not be opened again.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dalCnt <= 6'h00;
    end else if (cmd == CMD_WRA) begin
      dalCnt <= 6'(DalWait);
    end else if (dalCnt != 6'h00) begin
      dalCnt <= dalCnt - 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (cmd == CMD_WRA) begin
      dalBank <= bank;
    end
  end

  sequence rdPre;
    dramDqsOeN ##1 (!dramDqsOeN && !dramDqs);
  endsequence
  sequence rdPost;
    !dramDqsOeN ##1 dramDqsOeN;
  endsequence
  sequence wrPre;
    ctrlDqsOeN ##1 (!ctrlDqsOeN && !ctrlDqs);
  endsequence
  sequence wrBurst;
    (!ctrlDqsOeN && ctrlDqs) ##1 (!ctrlDqsOeN && !ctrlDqs) ##1
    (!ctrlDqsOeN && ctrlDqs) ##1 (!ctrlDqsOeN && !ctrlDqs);
  endsequence
  sequence wrPost;
    !ctrlDqsOeN ##1 ctrlDqsOeN;
  endsequence

  a_col_spacing: assert property (isCol |=> (!isCol) [*3])
    else $error("column commands closer than four cycles");
  a_mode_spacing: assert property (cmd == CMD_MRS |=> (cmd != CMD_MRS) [*3])
    else $error("mode set commands closer than four cycles");
  a_mode_update_wait: assert property (cmd == CMD_MRS |=> quiet [*8] ##1 quiet [*3])
    else $error("command issued during mode update delay");
  a_read_to_pre: assert property (cmd == CMD_RD |=> (cmd != CMD_PRE) [*3])
    else $error("precharge too soon after read");
  a_write_to_read: assert property (cmd == CMD_WRA |=> (cmd != CMD_RD) [*8] ##1
                                   (cmd != CMD_RD) [*6])
    else $error("read too soon after write");
  a_dal_bank_reuse: assert property (cmd == CMD_ACT && bank == dalBank |-> dalCnt == 6'h00)
    else $error("bank opened inside auto-precharge write interval");
  a_act_act_gap: assert property (cmd == CMD_ACT |=> !(cmd == CMD_ACT && bank == $past(bank)))
    else $error("activate to activate period too short");
  a_rd_strobe_on: assert property (cmd == CMD_RD |-> ##7 rdPre)
    else $error("read strobe preamble misplaced");
  a_rd_strobe_off: assert property (cmd == CMD_RD |-> ##13 rdPost)
    else $error("read strobe not released on time");
  a_wr_strobe_frame: assert property (cmd == CMD_WRA |-> ##5 wrPre ##1 wrBurst ##1 wrPost)
    else $error("write strobe framing wrong");

endmodule : dct_link_checker

// File: dct_link_if.sv
`timescale 1ns/10ps
interface dct_link_if;
  import dct_pkg::*;

  dct_cmd_t                cmd;
  logic [BANK_W-1:0]       bank;
  logic [ADDR_W-1:0]       addr;
  logic [DQ_W-1:0]         ctrlDq;
  logic                    ctrlDqOeN;
  logic                    ctrlDqs;
  logic                    ctrlDqsOeN;
  logic [DQ_W-1:0]         dramDq;
  logic                    dramDqOeN;
  logic                    dramDqs;
  logic                    dramDqsOeN;
  logic [DQ_W-1:0]         dq;
  logic                    dqs;

  // Shared data and strobe wires: the memory end owns them while its enable is low, the controller otherwise.
  assign dq  = dramDqOeN ? ctrlDq : dramDq;
  assign dqs = dramDqsOeN ? ctrlDqs : dramDqs;

  modport ctrl (
    output cmd, bank, addr, ctrlDq, ctrlDqOeN, ctrlDqs, ctrlDqsOeN,
    input  dq, dqs
  );

  modport dram (
    input  cmd, bank, addr, dq, dqs,
    output dramDq, dramDqOeN, dramDqs, dramDqsOeN
  );

endinterface : dct_link_if

// File: dct_pkg.sv
package dct_pkg;

  // Link widths and storage shape.
  localparam int BANK_W      = 3;
  localparam int NUM_BANKS   = 8;
  localparam int ADDR_W      = 6;
  localparam int MODE_WR_W   = 4;
  localparam int DQ_W        = 32;
  localparam int BEAT_W      = 2;
  localparam int BURST_LEN   = 8;
  localparam int BURST_WORDS = BURST_LEN / 2;
  localparam int MEM_DEPTH   = 512;

  typedef logic [5:0] dct_cnt_t;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_MRS = 3'h1,
    CMD_ACT = 3'h2,
    CMD_PRE = 3'h3,
    CMD_RD  = 3'h4,
    CMD_WRA = 3'h5
  } dct_cmd_t;

  typedef enum logic [1:0] {
    OP_RD  = 2'h0,
    OP_WR  = 2'h1,
    OP_MRS = 2'h2
  } dct_op_t;

  // Times in picoseconds; one link cycle is one sys_clk period.
  localparam int CK_PS              = 40000;
  localparam int DLL_OFF_CK_MIN_PS  = 8000;
  localparam int RTP_PS             = 7500;
  localparam int WTR_PS             = 7500;
  localparam int WR_PS              = 15000;
  localparam int MOD_PS             = 15000;
  // Speed-bin figures, plain defaults for the selected grade.
  localparam int RCD_PS             = 15000;
  localparam int RP_PS              = 15000;
  localparam int RAS_PS             = 36000;
  localparam int RC_PS              = 51000;
  // Strobe framing in thousandths of a clock period.
  localparam int PRE_AMB_MCK        = 900;
  localparam int POST_AMB_MCK       = 300;

  function automatic int cyc_up(input int ps);
    return (ps + CK_PS - 1) / CK_PS;
  endfunction : cyc_up

  function automatic int cyc_max(input int n, input int ps);
    return (n > cyc_up(ps)) ? n : cyc_up(ps);
  endfunction : cyc_max

  localparam dct_cnt_t RTP_CYC      = dct_cnt_t'(cyc_max(4, RTP_PS));
  localparam dct_cnt_t WTR_CYC      = dct_cnt_t'(cyc_max(4, WTR_PS));
  localparam dct_cnt_t WR_CYC       = dct_cnt_t'(cyc_up(WR_PS));
  localparam dct_cnt_t MRD_CYC      = dct_cnt_t'(4);
  localparam dct_cnt_t MOD_CYC      = dct_cnt_t'(cyc_max(12, MOD_PS));
  localparam dct_cnt_t CCD_CYC      = dct_cnt_t'(4);
  localparam dct_cnt_t RCD_CYC      = dct_cnt_t'(cyc_up(RCD_PS));
  localparam dct_cnt_t RP_CYC       = dct_cnt_t'(cyc_up(RP_PS));
  localparam dct_cnt_t RAS_CYC      = dct_cnt_t'(cyc_up(RAS_PS));
  localparam dct_cnt_t RC_CYC       = dct_cnt_t'(cyc_up(RC_PS));
  localparam dct_cnt_t PRE_AMB_CYC  = dct_cnt_t'((PRE_AMB_MCK + 999) / 1000);
  localparam dct_cnt_t POST_AMB_CYC = dct_cnt_t'((POST_AMB_MCK + 999) / 1000);

  // Latencies and burst, counted in link cycles.
  localparam dct_cnt_t CAS_LAT      = 6'h09;
  localparam dct_cnt_t CAS_WR_LAT   = 6'h07;
  localparam dct_cnt_t BURST_CYC    = dct_cnt_t'(BURST_WORDS);
  localparam dct_cnt_t RD_END       = CAS_LAT + BURST_CYC;
  localparam dct_cnt_t WR_END       = CAS_WR_LAT + BURST_CYC;

  // Programmed write recovery; must not be below WR_CYC.
  localparam logic [MODE_WR_W-1:0] WR_PROG = 4'h5;
  localparam dct_cnt_t DAL_CYC      = dct_cnt_t'(WR_PROG) + RP_CYC;

endpackage : dct_pkg

// File: ddr3_command_timing_rules_bench.sv
`timescale 1ns/10ps
module ddr3_command_timing_rules_bench;
  import dct_pkg::*;

  localparam int W = BURST_WORDS * DQ_W;

  logic                  sys_clk   = 1'b0;
  logic                  sys_rst   = 1'b1;
  logic                  reqValid  = 1'b0;
  logic                  reqReady;
  dct_op_t               reqOp     = OP_RD;
  logic [BANK_W-1:0]     reqBank   = '0;
  logic [ADDR_W-1:0]     reqAddr   = '0;
  logic [W-1:0]          reqWrData = '0;
  logic                  rspValid;
  logic [W-1:0]          rspData;
  logic                  dllOffClkOk;
  logic [NUM_BANKS-1:0]  bankOpen;
  logic [NUM_BANKS-1:0]  bankBusy;
  logic [MODE_WR_W-1:0]  modeWr;
  logic                  cmdError;
  logic                  errSeen   = 1'b0;
  int                    bad_count = 0;
  int                    n_checks  = 0;
  int                    cycles    = 0;
  logic [W-1:0]          model [int];
  logic [W-1:0]          expQ [$];

  dct_link_if link ();

  dct_ctrl_end i_dct_ctrl_end (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link.ctrl), .reqValid(reqValid),
    .reqReady(reqReady), .reqOp(reqOp), .reqBank(reqBank), .reqAddr(reqAddr),
    .reqWrData(reqWrData), .rspValid(rspValid), .rspData(rspData),
    .dllOffClkOk(dllOffClkOk)
  );

  dct_dram_end i_dct_dram_end (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link.dram), .bankOpen(bankOpen),
    .bankBusy(bankBusy), .modeWr(modeWr), .cmdError(cmdError)
  );

  dct_link_checker i_dct_link_checker (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(link.cmd), .bank(link.bank),
    .ctrlDqs(link.ctrlDqs), .ctrlDqsOeN(link.ctrlDqsOeN), .dramDqs(link.dramDqs),
    .dramDqsOeN(link.dramDqsOeN)
  );

  always #20 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // Holds the request until a negedge sees reqReady, so the next posedge takes it.
  task automatic send(input dct_op_t op, input logic [BANK_W-1:0] b,
                      input logic [ADDR_W-1:0] a, input logic [W-1:0] d);
    @(negedge sys_clk);
    reqValid  = 1'b1;
    reqOp     = op;
    reqBank   = b;
    reqAddr   = a;
    reqWrData = d;
    while (reqReady !== 1'b1) @(negedge sys_clk);
    if (op == OP_WR) model[{b, a[5:2]}] = d;
    if (op == OP_RD) expQ.push_back(model[{b, a[5:2]}]);
    @(negedge sys_clk);
    reqValid = 1'b0;
  endtask : send

  // Outputs are looked at half a cycle after the edge that launches them.
  always @(negedge sys_clk) begin
    if (rspValid === 1'b1) begin
      if (expQ.size() == 0) check("spare response", W'(1), W'(0));
      else check("read data", rspData, expQ.pop_front());
    end
    if (cmdError === 1'b1) errSeen <= 1'b1;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    logic [BANK_W-1:0] b;
    logic [ADDR_W-1:0] a;
    void'($urandom(98));
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    check("dll off clock ok", W'(dllOffClkOk), W'(1));
    check("write recovery", W'(modeWr), W'(WR_PROG));
    send(OP_MRS, 3'h0, 6'h07, '0);
    repeat (2) @(negedge sys_clk);
    check("write recovery", W'(modeWr), W'(4'h7));
    send(OP_MRS, 3'h0, 6'h05, '0);
    repeat (8) @(negedge sys_clk);
    check("write recovery", W'(modeWr), W'(4'h5));
    for (int i = 0; i < NUM_BANKS; i++) begin
      send(OP_WR, 3'(i), 6'h00, {$urandom, $urandom, $urandom, $urandom});
    end
    for (int i = 0; i < 16; i++) begin
      b = 3'($urandom_range(7));
      a = 6'($urandom);
      send(OP_WR, b, a, {$urandom, $urandom, $urandom, $urandom});
      send(OP_RD, b, a, '0);
      send(OP_RD, b + 3'h1, 6'h00, '0);
    end
    repeat (40) @(negedge sys_clk);
    check("pending reads", W'(expQ.size()), W'(0));
    check("open banks", W'(bankOpen), W'(0));
    check("illegal command flag", W'(errSeen), W'(0));
    final_report();
  end

endmodule : ddr3_command_timing_rules_bench
